// File: common/ucs_pkg.sv
// Purpose: Shared constants and carriers for the endpoint configuration and status block.
// Assumes: Byte-wide register port with a 4-bit register index.
// Notes: Register indices equal byte addresses on the plain register port.
// ============================================================================
// Package
package ucs_pkg;
    // ========================================================================
    // Sizes
    localparam int NUM_EP = 5;             // Endpoints zero to four.
    localparam int FIFO_BYTES = 176;       // Total endpoint memory in bytes.
    localparam logic [9:0] FIFO_CAP = 10'h0B0; // Same capacity at sum width.
    // ========================================================================
    // Register indices
    localparam logic [3:0] OFS_FRAME_ERR = 4'h0;
    localparam logic [3:0] OFS_FRAME_LOW = 4'h1;
    localparam logic [3:0] OFS_EP_SELECT = 4'h2;
    localparam logic [3:0] OFS_FIFO_RST = 4'h3;
    localparam logic [3:0] OFS_EP_CTRL = 4'h4;
    localparam logic [3:0] OFS_EP_TYPE = 4'h5;
    localparam logic [3:0] OFS_EP_SIZE = 4'h6;
    localparam logic [3:0] OFS_EP_STA0 = 4'h7;
    localparam logic [3:0] OFS_EP_STA1 = 4'h8;
    localparam logic [3:0] OFS_EP_FLOWEN = 4'h9;
    // ========================================================================
    // Field positions
    localparam int BIT_CRC_FLAG = 4;
    localparam int BIT_STALL_REQ = 5;
    localparam int BIT_STALL_CANCEL = 4;
    localparam int BIT_TOGGLE_RST = 3;
    localparam int BIT_EP_ON = 0;
    localparam int BIT_DIR = 0;
    localparam int POS_KIND = 6;
    localparam int POS_SIZE = 4;
    localparam int POS_BANK = 2;
    localparam int BIT_CLAIM = 1;
    localparam int BIT_CFG_OK = 7;
    localparam int BIT_OVF = 6;
    localparam int BIT_UNF = 5;
    localparam int BIT_FLOW_EN = 7;
    // ========================================================================
    // Reset values and codes
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] EP_MAX = 3'h4;
    localparam logic [2:0] SIZE_MAX = 3'h3;
    localparam logic [7:0] SIZE_BASE = 8'h08;
    localparam logic [1:0] BUSY_NONE = 2'h0;
    localparam logic [1:0] BUSY_TWO = 2'h2;

    typedef enum logic [1:0] {
        KIND_CONTROL,
        KIND_ISO,
        KIND_BULK,
        KIND_INTR
    } ucs_kind_t;

    // Per-endpoint events from the packet engine, one-cycle pulses.
    typedef struct packed {
        logic setup_rx;      // A SETUP packet landed.
        logic setup_in;      // Direction of the data stage after it.
        logic overflow;      // Isochronous overflow.
        logic underflow;     // Isochronous underflow.
        logic toggle_load;   // Load the toggle from toggle_val.
        logic toggle_val;    // Toggle seen (OUT) or next to send (IN).
        logic bank_fill;     // A bank became busy.
        logic bank_free;     // A bank was released.
    } ucs_ep_evt_t;

    // Start-of-frame report from the packet engine.
    typedef struct packed {
        logic sof;           // One-cycle pulse per start-of-frame.
        logic crc_bad;       // Frame number was corrupted.
        logic [10:0] frame;  // Eleven-bit frame number.
    } ucs_sof_t;

    // Per-endpoint configuration handed to the packet engine.
    typedef struct packed {
        logic on;
        ucs_kind_t kind;
        logic dir_in;
        logic [2:0] size;
        logic [1:0] banks;
        logic claim;
        logic cfg_ok;
        logic stall;
        logic flow_irq;
        logic fifo_clear;
        logic toggle_reset;  // One-cycle pulse.
        logic stall_cancel;  // One-cycle pulse.
    } ucs_ep_cfg_t;
endpackage : ucs_pkg

// File: verilog/ucs_endpoint_regs.sv
// Purpose: Endpoint selection, control, configuration and status registers.
// Assumes: Packet engine supplies one-cycle event pulses synchronous to clk.
// Notes: Per-endpoint copies are shown through the selected endpoint window.
// ============================================================================
`timescale 1ns/1ps

module ucs_endpoint_regs
    import ucs_pkg::*;
#(
    parameter int N_EP = NUM_EP
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire ucs_sof_t sof_in,
    input wire ucs_ep_evt_t [N_EP-1:0] ep_evt,
    output logic frame_start_flag,
    output ucs_ep_cfg_t [N_EP-1:0] ep_cfg
);
    // ========================================================================
    // Shared registers
    logic [7:0] rdata_ff;            // Read data, valid the cycle after a read.
    logic crc_flag_ff;               // Corrupted frame number flag.
    logic [7:0] frame_low_ff;        // Low byte of the last frame number.
    logic sof_ff;                    // Start-of-frame flag pulse to the engine.
    logic [2:0] sel_ff;              // Endpoint selector.
    logic [N_EP-1:0] fifo_clr_ff;    // Endpoint FIFO clear bits.

    // Per-endpoint copies of every endpoint register.
    logic [N_EP-1:0] on_ff;
    logic [N_EP-1:0] stall_ff;
    logic [N_EP-1:0] cancel_ff;
    logic [N_EP-1:0] trst_ff;
    logic [1:0] kind_ff [N_EP];
    logic [N_EP-1:0] dir_ff;
    logic [2:0] size_ff [N_EP];
    logic [1:0] bank_ff [N_EP];
    logic [N_EP-1:0] claim_ff;
    logic [N_EP-1:0] ok_ff;
    logic [7:0] memory_claim_ff [N_EP];     // Bytes reserved by each endpoint.
    logic [N_EP-1:0] ovf_ff;
    logic [N_EP-1:0] unf_ff;
    logic [N_EP-1:0] flow_en_ff;
    logic [N_EP-1:0] tog_ff;
    logic [1:0] busy_ff [N_EP];
    logic [N_EP-1:0] cur_ff;
    logic [N_EP-1:0] cdir_ff;
    logic [N_EP-1:0] irq_ff;

    // ========================================================================
    // Address decode
    wire wr_frame = reg_wr && (reg_addr == OFS_FRAME_ERR);
    wire wr_sel = reg_wr && (reg_addr == OFS_EP_SELECT);
    wire wr_fifo = reg_wr && (reg_addr == OFS_FIFO_RST);
    // A selector above four maps to no endpoint, so writes through it are lost.
    wire sel_ok = (sel_ff <= EP_MAX);
    wire wr_ctrl = reg_wr && sel_ok && (reg_addr == OFS_EP_CTRL);
    wire wr_type = reg_wr && sel_ok && (reg_addr == OFS_EP_TYPE);
    wire wr_size = reg_wr && sel_ok && (reg_addr == OFS_EP_SIZE);
    wire wr_sta0 = reg_wr && sel_ok && (reg_addr == OFS_EP_STA0);
    wire wr_flow = reg_wr && sel_ok && (reg_addr == OFS_EP_FLOWEN);

    // ========================================================================
    // Memory allocation check for the selected endpoint
    wire [2:0] new_size = reg_wdata[POS_SIZE +: 3];
    wire [1:0] new_bank = reg_wdata[POS_BANK +: 2];
    wire [7:0] one_bank = SIZE_BASE << new_size[1:0];
    wire [7:0] need = new_bank[0] ? {one_bank[6:0], 1'b0} : one_bank;
    logic [9:0] used_total;
    logic [7:0] sel_memory_claim;

    // Sums every reservation; the selected endpoint's own share is removed
    // below so that re-claiming an endpoint does not count it twice.
    always_comb begin
        used_total = 10'h000;
        sel_memory_claim = 8'h00;
        for (int i = 0; i < N_EP; i++) begin
            used_total = used_total + {2'b00, memory_claim_ff[i]};
            if (sel_ff == i[2:0]) begin
                sel_memory_claim = memory_claim_ff[i];
            end
        end
    end

    wire [9:0] used_other = used_total - {2'b00, sel_memory_claim};
    wire [9:0] used_after = used_other + {2'b00, need};
    // Endpoint zero is a control endpoint and only ever gets a single bank.
    wire bank_fits = !new_bank[1] && !(new_bank[0] && (sel_ff == 3'h0));
    wire fit = (new_size <= SIZE_MAX) && bank_fits && (used_after <= FIFO_CAP);

    // ========================================================================
    // Read data selection
    logic [7:0] rd_mux;
    logic [7:0] ep_ctrl_v;
    logic [7:0] ep_type_v;
    logic [7:0] ep_size_v;
    logic [7:0] ep_sta0_v;
    logic [7:0] ep_sta1_v;
    logic [7:0] ep_flow_v;

    // Builds the selected endpoint's view; undefined bits stay zero.
    always_comb begin
        ep_ctrl_v = REG_RESET;
        ep_type_v = REG_RESET;
        ep_size_v = REG_RESET;
        ep_sta0_v = REG_RESET;
        ep_sta1_v = REG_RESET;
        ep_flow_v = REG_RESET;
        for (int i = 0; i < N_EP; i++) begin
            if (sel_ff == i[2:0]) begin
                ep_ctrl_v[BIT_STALL_REQ] = stall_ff[i];
                ep_ctrl_v[BIT_STALL_CANCEL] = cancel_ff[i];
                ep_ctrl_v[BIT_TOGGLE_RST] = trst_ff[i];
                ep_ctrl_v[BIT_EP_ON] = on_ff[i];
                ep_type_v[POS_KIND +: 2] = kind_ff[i];
                ep_type_v[BIT_DIR] = dir_ff[i];
                ep_size_v[POS_SIZE +: 3] = size_ff[i];
                ep_size_v[POS_BANK +: 2] = bank_ff[i];
                ep_size_v[BIT_CLAIM] = claim_ff[i];
                ep_sta0_v[BIT_CFG_OK] = ok_ff[i];
                ep_sta0_v[BIT_OVF] = ovf_ff[i];
                ep_sta0_v[BIT_UNF] = unf_ff[i];
                ep_sta0_v[POS_BANK +: 2] = {1'b0, tog_ff[i]};
                ep_sta0_v[1:0] = busy_ff[i];
                ep_sta1_v[2] = cdir_ff[i];
                // Control endpoints have no bank switching to report.
                ep_sta1_v[1:0] = {1'b0, cur_ff[i] && (kind_ff[i] != KIND_CONTROL)};
                ep_flow_v[BIT_FLOW_EN] = flow_en_ff[i];
            end
        end
    end

    // Register index to read value; unmapped indices read zero.
    always_comb begin
        case (reg_addr)
            OFS_FRAME_ERR: rd_mux = {3'b000, crc_flag_ff, 4'h0};
            OFS_FRAME_LOW: rd_mux = frame_low_ff;
            OFS_EP_SELECT: rd_mux = {5'h00, sel_ff};
            OFS_FIFO_RST: rd_mux = {{(8 - N_EP){1'b0}}, fifo_clr_ff};
            OFS_EP_CTRL: rd_mux = ep_ctrl_v;
            OFS_EP_TYPE: rd_mux = ep_type_v;
            OFS_EP_SIZE: rd_mux = ep_size_v;
            OFS_EP_STA0: rd_mux = ep_sta0_v;
            OFS_EP_STA1: rd_mux = ep_sta1_v;
            OFS_EP_FLOWEN: rd_mux = ep_flow_v;
            default: rd_mux = REG_RESET;
        endcase
    end

    // ========================================================================
    // Read data register: data stands only in the cycle after the strobe.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= REG_RESET;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : REG_RESET;
        end
    end

    // ========================================================================
    // Frame registers. A new frame start rewrites the CRC flag in the same
    // cycle the frame-start flag pulses, so both always describe one frame.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crc_flag_ff <= 1'b0;
            frame_low_ff <= REG_RESET;
            sof_ff <= 1'b0;
        end else begin
            sof_ff <= sof_in.sof;
            if (sof_in.sof) begin
                crc_flag_ff <= sof_in.crc_bad;
                frame_low_ff <= sof_in.frame[7:0];
            end else if (wr_frame) begin
                crc_flag_ff <= reg_wdata[BIT_CRC_FLAG];
            end
        end
    end

    // ========================================================================
    // Selector and FIFO clear bits.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_ff <= 3'h0;
            fifo_clr_ff <= '0;
        end else begin
            if (wr_sel) begin
                sel_ff <= reg_wdata[2:0];
            end
            if (wr_fifo) begin
                fifo_clr_ff <= reg_wdata[N_EP-1:0];
            end
        end
    end

    // ========================================================================
    // Per-endpoint state, one copy per endpoint.
    for (genvar e = 0; e < N_EP; e++) begin : g_ep
        wire me = (sel_ff == 3'(e));
        wire w_ctrl = wr_ctrl && me;
        wire w_size = wr_size && me;
        wire w_sta0 = wr_sta0 && me;
        wire is_iso = (kind_ff[e] == KIND_ISO);
        wire dbl = (bank_ff[e] == 2'h1);
        wire [1:0] busy_max = dbl ? BUSY_TWO : 2'h1;
        wire fill = ep_evt[e].bank_fill && (busy_ff[e] != busy_max);
        wire drain = ep_evt[e].bank_free && (busy_ff[e] != BUSY_NONE);

        // Control bits. A software stall request in the same cycle as a SETUP
        // wins, so the request is never silently lost.
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                on_ff[e] <= 1'b0;
                stall_ff[e] <= 1'b0;
                cancel_ff[e] <= 1'b0;
                trst_ff[e] <= 1'b0;
            end else begin
                cancel_ff[e] <= w_ctrl && reg_wdata[BIT_STALL_CANCEL];
                trst_ff[e] <= w_ctrl && reg_wdata[BIT_TOGGLE_RST];
                if (w_ctrl) begin
                    on_ff[e] <= reg_wdata[BIT_EP_ON];
                end
                if (w_ctrl && reg_wdata[BIT_STALL_REQ]) begin
                    stall_ff[e] <= 1'b1;
                end else if (w_ctrl && reg_wdata[BIT_STALL_CANCEL]) begin
                    stall_ff[e] <= 1'b0;
                end else if (ep_evt[e].setup_rx) begin
                    stall_ff[e] <= 1'b0;
                end
            end
        end

        // Configuration fields and the memory reservation.
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                kind_ff[e] <= 2'h0;
                dir_ff[e] <= 1'b0;
                size_ff[e] <= 3'h0;
                bank_ff[e] <= 2'h0;
                claim_ff[e] <= 1'b0;
                ok_ff[e] <= 1'b0;
                memory_claim_ff[e] <= 8'h00;
            end else begin
                if (wr_type && me) begin
                    kind_ff[e] <= reg_wdata[POS_KIND +: 2];
                    dir_ff[e] <= reg_wdata[BIT_DIR];
                end
                if (w_size) begin
                    size_ff[e] <= new_size;
                    bank_ff[e] <= new_bank;
                    claim_ff[e] <= reg_wdata[BIT_CLAIM];
                    if (reg_wdata[BIT_CLAIM]) begin
                        ok_ff[e] <= fit;
                        memory_claim_ff[e] <= fit ? need : 8'h00;
                    end else begin
                        ok_ff[e] <= 1'b0;
                        memory_claim_ff[e] <= 8'h00;
                    end
                end
            end
        end

        // Flow error flags: hardware sets, software writes zero to clear.
        // An event in the clearing cycle wins and the flag stays set.
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                ovf_ff[e] <= 1'b0;
                unf_ff[e] <= 1'b0;
                flow_en_ff[e] <= 1'b0;
                irq_ff[e] <= 1'b0;
            end else begin
                if (ep_evt[e].overflow && is_iso) begin
                    ovf_ff[e] <= 1'b1;
                end else if (w_sta0 && !reg_wdata[BIT_OVF]) begin
                    ovf_ff[e] <= 1'b0;
                end
                if (ep_evt[e].underflow && is_iso) begin
                    unf_ff[e] <= 1'b1;
                end else if (w_sta0 && !reg_wdata[BIT_UNF]) begin
                    unf_ff[e] <= 1'b0;
                end
                if (wr_flow && me) begin
                    flow_en_ff[e] <= reg_wdata[BIT_FLOW_EN];
                end
                irq_ff[e] <= flow_en_ff[e] && (ovf_ff[e] || unf_ff[e]);
            end
        end

        // Toggle, busy banks, current bank and control direction. A held FIFO
        // clear keeps the bank bookkeeping empty.
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                tog_ff[e] <= 1'b0;
                busy_ff[e] <= BUSY_NONE;
                cur_ff[e] <= 1'b0;
                cdir_ff[e] <= 1'b0;
            end else begin
                if (trst_ff[e] || fifo_clr_ff[e]) begin
                    tog_ff[e] <= 1'b0;
                end else if (ep_evt[e].toggle_load) begin
                    tog_ff[e] <= ep_evt[e].toggle_val;
                end
                if (fifo_clr_ff[e]) begin
                    busy_ff[e] <= BUSY_NONE;
                    cur_ff[e] <= 1'b0;
                end else begin
                    if (fill && !drain) begin
                        busy_ff[e] <= busy_ff[e] + 2'h1;
                    end else if (drain && !fill) begin
                        busy_ff[e] <= busy_ff[e] - 2'h1;
                    end
                    if (ep_evt[e].bank_free && dbl) begin
                        cur_ff[e] <= !cur_ff[e];
                    end
                end
                if (ep_evt[e].setup_rx) begin
                    cdir_ff[e] <= ep_evt[e].setup_in;
                end
            end
        end

        // Configuration bundle handed to the packet engine.
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                ep_cfg[e] <= '0;
            end else begin
                ep_cfg[e].on <= nxt_on(on_ff[e], w_ctrl, reg_wdata);
                ep_cfg[e].kind <= ucs_kind_t'(kind_ff[e]);
                ep_cfg[e].dir_in <= dir_ff[e];
                ep_cfg[e].size <= size_ff[e];
                ep_cfg[e].banks <= bank_ff[e];
                ep_cfg[e].claim <= claim_ff[e];
                ep_cfg[e].cfg_ok <= ok_ff[e];
                ep_cfg[e].stall <= stall_ff[e];
                ep_cfg[e].flow_irq <= irq_ff[e];
                ep_cfg[e].fifo_clear <= fifo_clr_ff[e];
                ep_cfg[e].toggle_reset <= trst_ff[e];
                ep_cfg[e].stall_cancel <= cancel_ff[e];
            end
        end
    end

    // Enable state that the next cycle will hold; used so the engine sees
    // the enable without an extra cycle of lag.
    function automatic logic nxt_on(input logic cur, input logic wr, input logic [7:0] d);
        nxt_on = wr ? d[BIT_EP_ON] : cur;
    endfunction : nxt_on

    // ========================================================================
    // Outputs
    assign reg_rdata = rdata_ff;
    assign frame_start_flag = sof_ff;

endmodule : ucs_endpoint_regs

// File: tb/ucs_endpoint_regs_props.sv
// Purpose: Port assertions for the endpoint register block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Attached by bind to every instance of the block.
`timescale 1ns/1ps
module ucs_endpoint_regs_props
    import ucs_pkg::*;
#(
    parameter int N_EP = NUM_EP
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire ucs_sof_t sof_in,
    input wire ucs_ep_evt_t [N_EP-1:0] ep_evt,
    input wire logic frame_start_flag,
    input wire ucs_ep_cfg_t [N_EP-1:0] ep_cfg
);
    // ========================================================================
    // Helper: last frame number low byte, kept so reads can be judged.
    logic [7:0] frame_lo_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_lo_ff <= 8'h00;
        end else if (sof_in.sof) begin
            frame_lo_ff <= sof_in.frame[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ========================================================================
    // Assertions
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data outside its slot.");
    AST_SOF_PULSE: assert property (sof_in.sof ##1 !sof_in.sof
        |-> frame_start_flag ##1 !frame_start_flag)
        else $error("Frame start flag pulse wrong.");
    AST_FLAG_CAUSE: assert property ($rose(frame_start_flag) |-> $past(sof_in.sof))
        else $error("Frame start flag without frame.");
    AST_CRC_SET: assert property (sof_in.sof && sof_in.crc_bad ##1 !sof_in.sof && !reg_wr
        ##1 reg_rd && reg_addr == OFS_FRAME_ERR && !sof_in.sof |=> reg_rdata == 8'h10)
        else $error("Corrupt frame flag not read back.");
    AST_FRAME_LOW: assert property (reg_rd && reg_addr == OFS_FRAME_LOW && !sof_in.sof
        |=> reg_rdata == frame_lo_ff)
        else $error("Frame low byte wrong.");
    AST_FRAME_RESV: assert property (reg_rd && reg_addr == OFS_FRAME_ERR |=> (reg_rdata & 8'hEF) == 8'h00)
        else $error("Frame status reserved bits set.");
    AST_SEL_RESV: assert property (reg_rd && reg_addr == OFS_EP_SELECT |=> reg_rdata[7:3] == 5'h00)
        else $error("Selector reserved bits set.");
    AST_RST_RESV: assert property (reg_rd && reg_addr == OFS_FIFO_RST |=> reg_rdata[7:5] == 3'h0)
        else $error("FIFO reset reserved bits set.");
    AST_CTRL_RESV: assert property (reg_rd && reg_addr == OFS_EP_CTRL |=> (reg_rdata & 8'hC6) == 8'h00)
        else $error("Control reserved bits set.");
    AST_CANCEL_ONE: assert property (ep_cfg[1].stall_cancel && !$past(reg_wr)
        |=> !ep_cfg[1].stall_cancel)
        else $error("Stall cancel longer than one cycle.");
    AST_TOGGLE_ONE: assert property (ep_cfg[1].toggle_reset && !$past(reg_wr)
        |=> !ep_cfg[1].toggle_reset)
        else $error("Toggle reset longer than one cycle.");
    AST_SETUP_CLR: assert property (ep_evt[1].setup_rx && !reg_wr |=> ##1 !ep_cfg[1].stall)
        else $error("Stall survived a SETUP.");
    COV_BAD_FRAME: cover property (sof_in.sof && sof_in.crc_bad);
    COV_CANCEL: cover property (ep_cfg[1].stall_cancel);
    COV_SETUP: cover property (ep_evt[1].setup_rx);
endmodule : ucs_endpoint_regs_props

bind ucs_endpoint_regs ucs_endpoint_regs_props #(.N_EP(N_EP)) u_props (.clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sof_in, .ep_evt, .frame_start_flag, .ep_cfg);

// File: tb/ucs_host_model.sv
// Purpose: Packet engine stand-in raising frame and endpoint events.
// Assumes: Each event is a one-cycle pulse launched after a rising edge.
// Notes: Lines rest at zero between events, as the engine keeps them.
`timescale 1ns/1ps
module ucs_host_model
    import ucs_pkg::*;
(
    input wire logic clk,
    output ucs_sof_t sof_out,
    output ucs_ep_evt_t [NUM_EP-1:0] evt_out
);
    initial begin
        sof_out = '0;
        evt_out = '0;
    end
    // One frame start for one cycle, corrupted when bad is set.
    task automatic frame(input logic [10:0] num, input logic bad);
        @(posedge clk);
        sof_out <= '{1'b1, bad, num};
        @(posedge clk);
        sof_out <= '0;
    endtask : frame
    // One event pulse on one endpoint.
    task automatic pulse(input int ep, input ucs_ep_evt_t ev);
        @(posedge clk);
        evt_out[ep] <= ev;
        @(posedge clk);
        evt_out[ep] <= '0;
    endtask : pulse
endmodule : ucs_host_model

// File: tb/ucs_endpoint_regs_tb.sv
// Purpose: Self-checking bench for the endpoint register block.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: Scenarios run in order and build on earlier state.
`timescale 1ns/1ps
module ucs_endpoint_regs_tb;
    import ucs_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic frame_start_flag;
    ucs_sof_t sof_w;
    ucs_ep_evt_t [NUM_EP-1:0] evt_w;
    ucs_ep_cfg_t [NUM_EP-1:0] ep_cfg;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    ucs_endpoint_regs dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sof_in(sof_w), .ep_evt(evt_w), .frame_start_flag, .ep_cfg);
    ucs_host_model host (.clk, .sof_out(sof_w), .evt_out(evt_w));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // The tests need under two hundred cycles; the ceiling cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic t_frame();
        for (int a = 0; a < 11; a++) rd(a[3:0], 8'h00);
        host.frame(11'h5A7, 1'b1);
        #1 chk({7'h00, frame_start_flag}, 8'h01);
        rd(OFS_FRAME_ERR, 8'h10);
        rd(OFS_FRAME_LOW, 8'hA7);
        host.frame(11'h0C3, 1'b0);
        rd(OFS_FRAME_ERR, 8'h00);
        rd(OFS_FRAME_LOW, 8'hC3);
        $display("frame test done");
    endtask : t_frame
    task automatic t_ctrl();
        wr(OFS_FIFO_RST, 8'h1F);
        @(posedge clk);
        #1 chk({7'h00, ep_cfg[4].fifo_clear}, 8'h01);
        rd(OFS_FIFO_RST, 8'h1F);
        wr(OFS_FIFO_RST, 8'h00);
        wr(OFS_EP_CTRL, 8'h01);
        wr(OFS_EP_SELECT, 8'h01);
        wr(OFS_EP_CTRL, 8'h21);
        rd(OFS_EP_CTRL, 8'h21);
        wr(OFS_EP_CTRL, 8'h00);
        rd(OFS_EP_CTRL, 8'h20);
        host.pulse(1, 8'h80);
        rd(OFS_EP_CTRL, 8'h00);
        wr(OFS_EP_CTRL, 8'h20);
        wr(OFS_EP_CTRL, 8'h10);
        rd(OFS_EP_CTRL, 8'h00);
        host.pulse(1, 8'h0C);
        rd(OFS_EP_STA0, 8'h04);
        wr(OFS_EP_CTRL, 8'h08);
        rd(OFS_EP_STA0, 8'h00);
        wr(OFS_EP_SELECT, 8'h00);
        rd(OFS_EP_CTRL, 8'h01);
        $display("control test done");
    endtask : t_ctrl
    task automatic t_cfg();
        wr(OFS_EP_SELECT, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_EP_TYPE, {k[1:0], 6'h01});
            rd(OFS_EP_TYPE, {k[1:0], 6'h01});
        end
        wr(OFS_EP_SIZE, 8'h36);
        rd(OFS_EP_SIZE, 8'h36);
        rd(OFS_EP_STA0, 8'h80);
        wr(OFS_EP_SELECT, 8'h02);
        wr(OFS_EP_SIZE, 8'h32);
        rd(OFS_EP_STA0, 8'h00);
        wr(OFS_EP_SIZE, 8'h22);
        rd(OFS_EP_STA0, 8'h80);
        wr(OFS_EP_SIZE, 8'h2A);
        rd(OFS_EP_STA0, 8'h00);
        wr(OFS_EP_SIZE, 8'h00);
        wr(OFS_EP_SELECT, 8'h01);
        wr(OFS_EP_SIZE, 8'h34);
        rd(OFS_EP_STA0, 8'h00);
        $display("config test done");
    endtask : t_cfg
    task automatic t_flow();
        host.pulse(1, 8'h20);
        rd(OFS_EP_STA0, 8'h00);
        wr(OFS_EP_SELECT, 8'h03);
        wr(OFS_EP_TYPE, 8'h40);
        wr(OFS_EP_SIZE, 8'h02);
        wr(OFS_EP_FLOWEN, 8'h80);
        host.pulse(3, 8'h20);
        rd(OFS_EP_STA0, 8'hC0);
        chk({7'h00, ep_cfg[3].flow_irq}, 8'h01);
        host.pulse(3, 8'h10);
        rd(OFS_EP_STA0, 8'hE0);
        wr(OFS_EP_STA0, 8'hE0);
        rd(OFS_EP_STA0, 8'hE0);
        wr(OFS_EP_STA0, 8'h80);
        rd(OFS_EP_STA0, 8'h80);
        $display("flow test done");
    endtask : t_flow
    task automatic t_bank();
        wr(OFS_EP_SELECT, 8'h01);
        wr(OFS_EP_SIZE, 8'h06);
        for (int n = 0; n < 3; n++) host.pulse(1, 8'h02);
        rd(OFS_EP_STA0, 8'h82);
        host.pulse(1, 8'h01);
        rd(OFS_EP_STA0, 8'h81);
        rd(OFS_EP_STA1, 8'h01);
        host.pulse(0, 8'hC0);
        wr(OFS_EP_SELECT, 8'h00);
        rd(OFS_EP_STA1, 8'h04);
        $display("bank test done");
    endtask : t_bank
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_frame();
        t_ctrl();
        t_cfg();
        t_flow();
        t_bank();
        conclude();
    end
endmodule : ucs_endpoint_regs_tb
